// [inc/bdma_pkg.sv]
// constants and carrier types for the banked data memory addressing block
// Notes on behaviour
// RL1 - field zero indirect, bit4 semi-direct, else direct
// RL2 - direct mode hits global register, pointer ignored
// RL3 - banked registers never reached by direct mode
// RL4 - semi-direct: pointer high nibble plus field low nibble
// RL5 - pointer F0h with field 1Fh hits FFh
// RL6 - pointer 00h with field 1Fh hits bank0 0Fh
// RL7 - pointer lives at global 04h, always direct
// RL8 - pointer bit 7 picks block, bank picks within
// RL9 - bank select writes pointer bits 4..6 only
// RL10 - software sets bit 7 separately for block change
// RL11 - single-bit set/clear of pointer bit 7 supported
// RL12 - indirect uses full 8-bit pointer as address
// RL13 - field zero accesses pointed location, not zero
// RL14 - indirect 01h-0Fh global, higher values banks 1-F
// RL15 - bank zero unreachable indirectly, semi-direct only
// RL16 - pointer increment wraps FFh to 00h
// RL17 - location 00h has no storage
// RL18 - every reachable register is eight bits
// RL19 - location 02h shows program counter low byte
// RL20 - port data drives pins, reads pin levels
// RL21 - missing port location acts as plain register
// RL22 - port control written only by port-config instruction
// RL23 - mode register picks which port control register
// RL24 - address resolved same cycle; pointer write visible next
package bdma_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned NUM_CTRL = 4;

  // global register offsets
  localparam logic [3:0] LOC_INDIRECT = 4'h0;
  localparam logic [3:0] LOC_REALTIME = 4'h1;
  localparam logic [3:0] LOC_PC_LOW = 4'h2;
  localparam logic [3:0] LOC_STATUS = 4'h3;
  localparam logic [3:0] LOC_POINTER = 4'h4;
  localparam logic [3:0] LOC_PORT_A = 4'h5;
  localparam logic [3:0] LOC_PORT_E = 4'h9;

  // field and pointer positions
  localparam int unsigned FIELD_SEMI_BIT = 4;
  localparam int unsigned PTR_BLOCK_BIT = 7;
  localparam int unsigned PTR_BANK_LSB = 4;

  // reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] GLOB_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'hFF;

  // mode low bits select the control register; index 0 is direction (1 = input)
  localparam logic [1:0] CTRL_DIR_IDX = 2'h0;

  typedef enum logic [2:0] {
    BDMA_OP_READ  = 3'h0,
    BDMA_OP_WRITE = 3'h1,
    BDMA_OP_BSET  = 3'h2,
    BDMA_OP_BCLR  = 3'h3,
    BDMA_OP_INC   = 3'h4
  } bdma_op_t;

  typedef struct packed {
    logic       valid;
    bdma_op_t   op;
    logic [4:0] register_field;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } bdma_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] addr;
    logic       banked;
  } bdma_ans_t;

endpackage

// [hw/bdma_core.sv]
// data memory address resolution, global registers, banked memory and ports
`timescale 1ns/1ps
`default_nettype none

module bdma_core #(
  parameter bit HAS_PORT_C = 1'b1,
  parameter bit HAS_PORT_D = 1'b1,
  parameter bit HAS_PORT_E = 1'b1
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // register access from the execute stage
  input  wire bdma_pkg::bdma_req_t acc_req,
  output var  bdma_pkg::bdma_ans_t acc_ans,
  // bank select instruction
  input  wire logic                bank_sel_valid,
  input  wire logic [2:0]          bank_sel_value,
  // mode write and port configuration instruction
  input  wire logic                mode_wr_valid,
  input  wire logic [7:0]          mode_wr_data,
  input  wire logic                port_cfg_valid,
  input  wire logic [2:0]          port_cfg_port,
  input  wire logic [7:0]          port_cfg_data,
  // program counter low byte
  input  wire logic [7:0]          program_counter_low,
  output logic                     pc_load,
  output logic [7:0]               pc_load_data,
  // state seen by the core
  output logic [7:0]               file_select_pointer,
  output logic [7:0]               mode_value,
  // port pins, eight per port, port a in the low byte
  input  wire logic [39:0]         port_pin_in,
  output logic [39:0]              port_pin_out,
  output logic [39:0]              port_pin_oe
);

  localparam logic [4:0] PORT_PRESENT = {HAS_PORT_E, HAS_PORT_D, HAS_PORT_C, 2'b11};

  // storage
  logic [7:0] glob_q [16];
  logic [7:0] bank_mem [256];
  logic [7:0] ctrl_q [5][4];
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] mode_q;
  logic [7:0] oe_q [5];
  logic [39:0] pin_meta_q;
  logic [39:0] pin_sync_q;

  // address decode
  wire bdma_pkg::bdma_req_t req = acc_req;
  wire logic [4:0] fld = req.register_field;
  wire logic       is_indirect = (fld == 5'h00); // RL1 RL13
  wire logic       is_semi = fld[bdma_pkg::FIELD_SEMI_BIT]; // RL1
  wire logic       ind_global = (ptr_q[7:4] == 4'h0); // RL14
  // direct mode never selects the banked array; bank 0 only via semi-direct
  wire logic       tgt_bank = is_semi | (is_indirect & ~ind_global); // RL3 RL15
  wire logic [7:0] semi_addr = {ptr_q[7:4], fld[3:0]}; // RL4 RL5 RL6 RL8
  wire logic [7:0] tgt_bidx = is_semi ? semi_addr : ptr_q; // RL12
  wire logic [3:0] tgt_gidx = is_indirect ? ptr_q[3:0] : fld[3:0]; // RL2 RL14
  wire logic [7:0] eff_addr = is_semi ? semi_addr :
                              (is_indirect ? ptr_q : {4'h0, fld[3:0]}); // RL24

  // read side of the global bank
  logic [7:0] gval;
  always_comb begin
    gval = glob_q[tgt_gidx];
    if (tgt_gidx == bdma_pkg::LOC_INDIRECT) begin
      gval = 8'h00; // RL17
    end else if (tgt_gidx == bdma_pkg::LOC_PC_LOW) begin
      gval = program_counter_low; // RL19
    end else if (tgt_gidx == bdma_pkg::LOC_POINTER) begin
      gval = ptr_q; // RL7
    end else if (tgt_gidx >= bdma_pkg::LOC_PORT_A && tgt_gidx <= bdma_pkg::LOC_PORT_E) begin
      // missing ports read back their latch like any plain register
      if (PORT_PRESENT[3'(tgt_gidx - bdma_pkg::LOC_PORT_A)]) begin
        gval = pin_byte(3'(tgt_gidx - bdma_pkg::LOC_PORT_A)); // RL20 RL21
      end
    end
  end

  function automatic logic [7:0] pin_byte(input logic [2:0] idx);
    pin_byte = pin_sync_q[idx*8 +: 8];
  endfunction

  wire logic [7:0] cur_val = tgt_bank ? bank_mem[tgt_bidx] : gval;
  wire logic [7:0] bit_mask = 8'(8'h01 << req.bit_sel);

  // read-modify-write result, all eight bits wide
  logic [7:0] new_val;
  always_comb begin
    unique case (req.op)
      bdma_pkg::BDMA_OP_WRITE: new_val = req.wdata;
      bdma_pkg::BDMA_OP_BSET:  new_val = cur_val | bit_mask; // RL11
      bdma_pkg::BDMA_OP_BCLR:  new_val = cur_val & ~bit_mask; // RL11
      bdma_pkg::BDMA_OP_INC:   new_val = 8'(cur_val + 8'h01); // RL16 RL18
      default:                 new_val = cur_val;
    endcase
  end

  wire logic do_write = req.valid & (req.op != bdma_pkg::BDMA_OP_READ);
  wire logic gwrite = do_write & ~tgt_bank;
  wire logic bwrite = do_write & tgt_bank;
  wire logic ptr_wr = gwrite & (tgt_gidx == bdma_pkg::LOC_POINTER);
  wire logic pc_wr = gwrite & (tgt_gidx == bdma_pkg::LOC_PC_LOW);
  // location 0 has no cell; pointer and pc low live elsewhere
  wire logic glob_wr = gwrite & (tgt_gidx != bdma_pkg::LOC_INDIRECT) & ~ptr_wr & ~pc_wr; // RL17

  // a full pointer write wins over a bank select in the same cycle
  always_comb begin
    ptr_d = ptr_q;
    if (ptr_wr) begin
      ptr_d = new_val; // RL7 RL10
    end else if (bank_sel_valid) begin
      ptr_d = {ptr_q[bdma_pkg::PTR_BLOCK_BIT], bank_sel_value, ptr_q[3:0]}; // RL9
    end
  end

  wire logic       cfg_ok = port_cfg_valid & (port_cfg_port < 3'd5)
                            && PORT_PRESENT[port_cfg_port];
  wire logic [1:0] cfg_sel = mode_q[1:0]; // RL23

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= bdma_pkg::PTR_RESET;
      mode_q <= bdma_pkg::MODE_RESET;
    end else begin
      ptr_q <= ptr_d; // RL24
      if (mode_wr_valid) begin
        mode_q <= mode_wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        glob_q[i] <= bdma_pkg::GLOB_RESET;
      end
    end else if (glob_wr) begin
      glob_q[tgt_gidx] <= new_val; // RL20 RL21
    end
  end

  // banked cells carry no reset, like a plain ram
  always_ff @(posedge sys_clk) begin
    if (bwrite) begin
      bank_mem[tgt_bidx] <= new_val; // RL4 RL12
    end
  end

  // control registers have no data address at all
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < 5; p++) begin
        oe_q[p] <= 8'h00;
        for (int c = 0; c < 4; c++) begin
          ctrl_q[p][c] <= bdma_pkg::CTRL_RESET;
        end
      end
    end else if (cfg_ok) begin
      ctrl_q[port_cfg_port][cfg_sel] <= port_cfg_data; // RL22 RL23
      if (cfg_sel == bdma_pkg::CTRL_DIR_IDX) begin
        oe_q[port_cfg_port] <= ~port_cfg_data;
      end
    end
  end

  // pins are asynchronous to the core clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 40'h00_0000_0000;
      pin_sync_q <= 40'h00_0000_0000;
    end else begin
      pin_meta_q <= port_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ans <= '0;
      pc_load <= 1'b0;
      pc_load_data <= 8'h00;
    end else begin
      acc_ans.valid <= req.valid;
      acc_ans.data <= cur_val;
      acc_ans.addr <= eff_addr;
      acc_ans.banked <= tgt_bank;
      pc_load <= pc_wr; // RL19
      pc_load_data <= new_val;
    end
  end

  assign file_select_pointer = ptr_q;
  assign mode_value = mode_q;

  for (genvar g = 0; g < 5; g++) begin : g_port
    assign port_pin_out[g*8 +: 8] = glob_q[5 + g]; // RL20
    assign port_pin_oe[g*8 +: 8] = oe_q[g];
  end

endmodule // bdma_core

`default_nettype wire

// [verif/bdma_core_sva.sv]
// assertions on the ports of the addressing block
`timescale 1ns/1ps
`default_nettype none
module bdma_core_sva (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                rst_n,
  // access, bank select and pointer
  input wire bdma_pkg::bdma_req_t acc_req,
  input wire bdma_pkg::bdma_ans_t acc_ans,
  input wire logic                bank_sel_valid,
  input wire logic [2:0]          bank_sel_value,
  input wire logic                pc_load,
  input wire logic [7:0]          pc_load_data,
  input wire logic [7:0]          file_select_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic [7:0] p  = file_select_pointer;
  wire logic [3:0] ph = file_select_pointer[7:4];
  wire logic [4:0] f  = acc_req.register_field;
  wire logic [3:0] fl = acc_req.register_field[3:0];
  wire logic [7:0] wd = acc_req.wdata;
  wire logic       v  = acc_req.valid;
  wire logic       wr = acc_req.valid && acc_req.op == bdma_pkg::BDMA_OP_WRITE;
  chk_ans_pulse: assert property (##1 acc_ans.valid == $past(v))
    else $error("answer valid wrong");
  chk_direct_addr: assert property (v && !f[4] && f != 5'h00
    |=> acc_ans.addr == {4'h0, $past(fl)} && !acc_ans.banked) else $error("direct address wrong");
  chk_semi_addr: assert property (v && f[4]
    |=> acc_ans.addr == {$past(ph), $past(fl)} && acc_ans.banked) else $error("semi address wrong");
  chk_indirect_addr: assert property (v && f == 5'h00
    |=> acc_ans.addr == $past(p) && acc_ans.banked == ($past(ph) != 4'h0))
    else $error("indirect address wrong");
  chk_bank_bits: assert property (bank_sel_valid && !v
    |=> p == (($past(p) & 8'h8F) | {1'b0, $past(bank_sel_value), 4'h0})) else $error("bank bits");
  chk_pointer_write: assert property (wr && f == 5'h04 && !bank_sel_valid
    |=> p == $past(wd)) else $error("pointer write lost");
  chk_block_bit: assert property (v && acc_req.op == bdma_pkg::BDMA_OP_BSET && f == 5'h04
    && acc_req.bit_sel == 3'h7 && !bank_sel_valid |=> p == ($past(p) | 8'h80)) else $error("bit 7");
  chk_pointer_wrap: assert property (v && acc_req.op == bdma_pkg::BDMA_OP_INC && f == 5'h04
    && p == 8'hFF |=> p == 8'h00) else $error("pointer wrap wrong");
  chk_pc_write: assert property (wr && f == 5'h02
    |=> pc_load && pc_load_data == $past(wd)) else $error("pc load wrong");
  cover property (bank_sel_valid);
  cover property (v && f == 5'h00 && ph != 4'h0);
  cover property (pc_load);
endmodule // bdma_core_sva
`default_nettype wire

// [verif/bdma_pad_model.sv]
// pin pads: driven pins follow the block, undriven ones the outside level
`timescale 1ns/1ps
`default_nettype none
module bdma_pad_model (
  // block side
  input  wire logic [39:0] pin_out,
  input  wire logic [39:0] pin_oe,
  // outside world
  input  wire logic [39:0] ext_level,
  output logic      [39:0] pin_level
);
  assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // bdma_pad_model
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the addressing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam bdma_pkg::bdma_op_t WR = bdma_pkg::BDMA_OP_WRITE;
  localparam bdma_pkg::bdma_op_t RD = bdma_pkg::BDMA_OP_READ;
  logic                sys_clk = 1'b0;
  logic                rst_n = 1'b0;
  bdma_pkg::bdma_req_t req = '0;
  wire bdma_pkg::bdma_ans_t ans;
  logic                bsv = 1'b0, mwv = 1'b0, pcv = 1'b0;
  logic [2:0]          bsd = 3'h0, pcp = 3'h0;
  logic [7:0]          mwd = 8'h00, cfd = 8'h00, pcl = 8'h00, p = 8'h00;
  logic [39:0]         ext = '0;
  wire logic [39:0]    pin, pout, poe;
  wire logic [7:0]     ptr, mode, pld;
  wire logic           pl;
  int                  fail_count = 0, comparisons = 0, cyc = 0;
  integer              seed = 32'h0000_993f;
  logic [31:0]         r;
  logic [4:0]          f;
  logic [7:0]          m [512];
  logic                k [512] = '{default: 1'b0};
  initial forever #5 sys_clk = ~sys_clk;
  bdma_core #(.HAS_PORT_E(1'b0)) bdma_core_inst (.sys_clk, .rst_n, .acc_req(req), .acc_ans(ans),
    .bank_sel_valid(bsv), .bank_sel_value(bsd), .mode_wr_valid(mwv), .mode_wr_data(mwd),
    .port_cfg_valid(pcv), .port_cfg_port(pcp), .port_cfg_data(cfd), .program_counter_low(pcl),
    .pc_load(pl), .pc_load_data(pld), .file_select_pointer(ptr), .mode_value(mode),
    .port_pin_in(pin), .port_pin_out(pout), .port_pin_oe(poe));
  bdma_pad_model bdma_pad_model_inst (.pin_out(pout), .pin_oe(poe), .ext_level(ext),
    .pin_level(pin));
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // effective location: banked flag over the 8-bit address
  function automatic logic [8:0] ea(input logic [4:0] fld, input logic [7:0] pv);
    if (fld == 5'h00) return {pv[7:4] != 4'h0, pv};
    if (fld[4]) return {1'b1, pv[7:4], fld[3:0]};
    return {5'h00, fld[3:0]};
  endfunction
  // valid stays up so back-to-back calls never touch it twice in one step
  task automatic acc(input bdma_pkg::bdma_op_t op, input logic [4:0] fld, input logic [7:0] d);
    req = '{1'b1, op, fld, 3'h7, d};
    @(negedge sys_clk);
  endtask
  task automatic go(input bdma_pkg::bdma_op_t op, input logic [4:0] fld, input logic [7:0] d);
    logic [8:0] a;
    a = ea(fld, p);
    acc(op, fld, d);
    chk({ans.banked, ans.addr}, a);
    if (k[a]) chk({1'b0, ans.data}, {1'b0, m[a]});
    if (op == WR && a != 9'h000) begin
      m[a] = d;
      k[a] = 1'b1;
    end
  endtask
  task automatic setp(input logic [7:0] d);
    acc(WR, 5'h04, d);
    p = d;
    chk({1'b0, ptr}, {1'b0, d});
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    m[0] = 8'h00;
    k[0] = 1'b1;
    setp(8'hF0);
    go(WR, 5'h1F, 8'hA5);
    setp(8'hFF);
    go(RD, 5'h00, 8'h00);
    setp(8'h00);
    go(WR, 5'h0F, 8'h5A);
    go(WR, 5'h1F, 8'h3C);
    go(RD, 5'h0F, 8'h00);
    go(WR, 5'h00, 8'h77);
    go(RD, 5'h00, 8'h00);
    go(WR, 5'h09, 8'h96);
    go(RD, 5'h09, 8'h00);
    setp(8'h8F);
    req.valid = 1'b0;
    bsd = 3'h2;
    bsv = 1'b1;
    @(negedge sys_clk);
    bsv = 1'b0;
    chk({1'b0, ptr}, 9'h0AF);
    acc(bdma_pkg::BDMA_OP_BCLR, 5'h04, 8'h00);
    chk({1'b0, ptr}, 9'h02F);
    acc(bdma_pkg::BDMA_OP_BSET, 5'h04, 8'h00);
    chk({1'b0, ptr}, 9'h0AF);
    setp(8'hFF);
    acc(bdma_pkg::BDMA_OP_INC, 5'h04, 8'h00);
    chk({1'b0, ptr}, 9'h000);
    pcl = 8'h6B;
    acc(RD, 5'h02, 8'h00);
    chk({1'b0, ans.data}, 9'h06B);
    acc(WR, 5'h02, 8'h3E);
    // the load strobe stands for one cycle only, so look before it drops
    chk({pl, pld}, 9'h13E);
    req.valid = 1'b0;
    @(negedge sys_clk);
    chk({1'b0, pl}, 9'h000);
    pcv = 1'b1;
    @(negedge sys_clk);
    pcv = 1'b0;
    // port a now drives, port b keeps its reset input direction
    ext = {$random(seed), 8'h00};
    acc(WR, 5'h05, 8'hC3);
    req.valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({poe[8], pout[7:0]}, {1'b0, 8'hC3});
    acc(RD, 5'h06, 8'h00);
    chk({1'b0, ans.data}, {1'b0, ext[15:8]});
    acc(RD, 5'h05, 8'h00);
    chk({1'b0, ans.data}, 9'h0C3);
    mwd = 8'h01;
    mwv = 1'b1;
    req.valid = 1'b0;
    @(negedge sys_clk);
    mwv = 1'b0;
    cfd = 8'hFF;
    pcv = 1'b1;
    @(negedge sys_clk);
    pcv = 1'b0;
    @(negedge sys_clk);
    chk({1'b0, mode}, 9'h001);
    chk({1'b0, poe[7:0]}, 9'h0FF);
    repeat (150) begin
      r = $random(seed);
      f = r[9] ? {1'b1, r[13:10]} : (r[8] ? 5'h00 : 5'h0A + 5'(r[13:10] % 6));
      setp((f == 5'h00 && r[7:4] == 4'h0) ? r[7:0] | 8'h0A : r[7:0]);
      go(r[14] ? WR : RD, f, r[23:16]);
    end
    results();
  end
endmodule // tb_top
bind bdma_core bdma_core_sva bdma_core_sva_inst (.sys_clk, .rst_n, .acc_req, .acc_ans,
  .bank_sel_valid, .bank_sel_value, .pc_load, .pc_load_data, .file_select_pointer);
`default_nettype wire
